// *** core/asb_cfg.svh ***
`ifndef ASB_CFG_SVH
`define ASB_CFG_SVH
// Contract
// - each input maps linearly between a bias point and a gain point
// - frequencies accept 0 to 400 Hz, levels accept 0 to 300 percent
// - primary input below bias level holds primary bias frequency
// - primary input above gain level holds primary gain frequency
// - secondary below bias level holds secondary bias frequency, default 20 %
// - secondary input above gain level holds secondary gain frequency
// - bias frequency above gain frequency gives a falling characteristic
// - reset: gains 50 Hz, biases 0 Hz, levels 0/20 % and 100 %
// - writing a gain frequency leaves the stored levels untouched
// - unit select 0 shows 0.1 %, 1 shows 0.01 V or 0.01 mA
// - full scale of 5 V, 10 V or 20 mA equals 100 %
// - unit select is writable at any time despite write protection
// - lamp lights when unit is 1 and a level is displayed
// - frequency write closer than about 5 % to its partner is rejected
// - level writes never alter the acceleration reference frequency
// - start alone runs the motor at the bias frequency at zero input
// - live calibration captures the applied input level
// - offline calibration stores the entered level value
// - secondary input drives the set point only while enabled
// - secondary spec 0 is 4-20 mA, 1 is 0-5 V, 2 is 0-10 V

// frequencies in 0.01 Hz, levels in 0.1 %
`define ASB_FREQ_MAX    16'h9c40
`define ASB_LVL_MAX     16'h0bb8
`define ASB_HS_LIMIT    16'h2ee0
`define ASB_RST_GAIN_F  16'h1388
`define ASB_RST_BIAS_F  16'h0000
`define ASB_RST_PBL     12'h000
`define ASB_RST_SBL     12'h0c8
`define ASB_RST_GL      12'h3e8
`define ASB_RST_ACCREF  16'h1388
// display scale, 100 % in 0.1 % steps and full scales in 0.01 V/mA
`define ASB_LVL_FULL    24'h0003e8
`define ASB_FS_5V       16'h01f4
`define ASB_FS_10V      16'h03e8
`define ASB_FS_20MA     16'h07d0
// secondary spec codes
`define ASB_SPEC_20MA   2'h0
`define ASB_SPEC_5V     2'h1
// write protect codes
`define ASB_WP_STOP     2'h0
`define ASB_WP_ANY      2'h2
`endif

// *** core/asb_pkg.sv ***
`include "asb_cfg.svh"
package asb_pkg;

	// parameter selection codes for the write and display ports
	typedef enum logic [3:0] {
		ASB_PGF = 4'h0,
		ASB_SGF = 4'h1,
		ASB_UNIT = 4'h2,
		ASB_PBF = 4'h3,
		ASB_PBL = 4'h4,
		ASB_PGL = 4'h5,
		ASB_SBF = 4'h6,
		ASB_SBL = 4'h7,
		ASB_SGL = 4'h8,
		ASB_ACC = 4'h9
	} asb_sel_t;

	typedef struct packed {
		logic [15:0] pgf;
		logic [15:0] sgf;
		logic        unit;
		logic [15:0] pbf;
		logic [11:0] pbl;
		logic [11:0] pgl;
		logic [15:0] sbf;
		logic [11:0] sbl;
		logic [11:0] sgl;
		logic [15:0] accref;
		logic        err;
		logic        refused;
		logic [15:0] setpt;
		logic [15:0] cmd;
		logic [15:0] disp;
		logic        lamp;
	} asb_state_t;

endpackage

// *** core/asb_interp.sv ***
`timescale 1ns/100ps
module asb_interp #(
	parameter int LW = 12,
	parameter int FW = 16
) (
	// point pair and input
	input  wire logic [LW-1:0] level_i,
	input  wire logic [LW-1:0] bias_lvl_i,
	input  wire logic [LW-1:0] gain_lvl_i,
	input  wire logic [FW-1:0] bias_f_i,
	input  wire logic [FW-1:0] gain_f_i,
	// result
	output logic      [FW-1:0] freq_o
);
	logic [LW-1:0]    dl;
	logic [LW-1:0]    dx;
	logic [FW-1:0]    df;
	logic [FW+LW-1:0] num;
	logic [FW+LW-1:0] q;

	// magnitude math keeps q no larger than df, so no overflow on either slope
	always_comb begin
		dl = gain_lvl_i - bias_lvl_i;
		dx = level_i - bias_lvl_i;
		df = (gain_f_i >= bias_f_i) ? gain_f_i - bias_f_i
			: bias_f_i - gain_f_i;
		num = (FW+LW)'(df) * (FW+LW)'(dx) + (FW+LW)'(dl >> 1);
		q = (dl != '0) ? num / (FW+LW)'(dl) : '0;
		if (level_i <= bias_lvl_i) begin
			freq_o = bias_f_i;
		end else if (level_i >= gain_lvl_i) begin
			freq_o = gain_f_i;
		end else if (gain_f_i >= bias_f_i) begin
			freq_o = bias_f_i + q[FW-1:0];
		end else begin
			freq_o = bias_f_i - q[FW-1:0];
		end
	end
endmodule

// *** core/asb_unit_conv.sv ***
`timescale 1ns/100ps
`include "asb_cfg.svh"
module asb_unit_conv #(
	parameter int LW = 12
) (
	// level and active specification
	input  wire logic [LW-1:0] level_i,
	input  wire logic          unit_i,
	input  wire logic [15:0]   full_scale_i,
	// display value
	output logic      [15:0]   disp_o
);
	logic [23:0] prod;
	logic [23:0] q;

	// 100 % maps to full scale, rounded to the nearest 0.01 unit
	always_comb begin
		prod = 24'(level_i) * 24'(full_scale_i) + (`ASB_LVL_FULL >> 1);
		q = prod / `ASB_LVL_FULL;
		disp_o = unit_i ? q[15:0] : 16'(level_i);
	end
endmodule

// *** core/asb_scaler.sv ***
`timescale 1ns/100ps
`include "asb_cfg.svh"
module asb_scaler
	import asb_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// digitised analog levels, 0.1 % steps
	input  wire logic [11:0] primary_level_i,
	input  wire logic [11:0] secondary_level_i,
	// input configuration
	input  wire logic [3:0]  primary_input_range_select_i,
	input  wire logic [1:0]  secondary_input_spec_select_i,
	input  wire logic        secondary_input_enable_i,
	// operation status
	input  wire logic        start_i,
	input  wire logic        running_i,
	input  wire logic [1:0]  parameter_write_protect_i,
	input  wire logic [15:0] high_speed_max_frequency_i,
	// parameter write port
	input  wire logic        wr_en_i,
	input  wire logic [3:0]  wr_sel_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        cal_live_i,
	// display port
	input  wire logic [3:0]  disp_sel_i,
	// frequency command path
	output logic      [15:0] freq_setpoint_o,
	output logic      [15:0] freq_command_o,
	output logic      [15:0] accel_reference_frequency_o,
	// panel
	output logic      [15:0] display_value_o,
	output logic             level_display_unit_select_o,
	output logic             ampere_unit_lamp_o,
	output logic             calibration_save_error_o,
	output logic             wr_refused_o
);

	//--------------------------------------------------------------
	// helpers
	//--------------------------------------------------------------

	// level parameters of either input
	function automatic logic is_level(input logic [3:0] s);
		return s == ASB_PBL || s == ASB_PGL || s == ASB_SBL
			|| s == ASB_SGL;
	endfunction

	// about 5 % apart: gap times 20 reaches the larger frequency
	function automatic logic gap_ok(input logic [15:0] a,
		input logic [15:0] b);
		logic [20:0] d;
		logic [15:0] big;
		d = (a > b) ? 21'(a - b) : 21'(b - a);
		big = (a > b) ? a : b;
		return (d * 21'd20) >= 21'(big);
	endfunction

	//--------------------------------------------------------------
	// state and datapath
	//--------------------------------------------------------------

	asb_state_t  st_reg;
	asb_state_t  st_next;
	logic [15:0] f_pri;
	logic [15:0] f_sec;
	logic [15:0] f_sel;
	logic [15:0] fs_pri;
	logic [15:0] fs_sec;
	logic [11:0] conv_lvl;
	logic [15:0] conv_fs;
	logic [15:0] conv_out;
	logic [15:0] val;
	logic [15:0] partner;
	logic        allow;
	logic        in_range;
	logic        hs_block;
	logic        is_freq;
	logic        gap_bad;

	asb_interp #(
		.LW(12),
		.FW(16)
	) u_pri (
		.level_i    (primary_level_i),
		.bias_lvl_i (st_reg.pbl),
		.gain_lvl_i (st_reg.pgl),
		.bias_f_i   (st_reg.pbf),
		.gain_f_i   (st_reg.pgf),
		.freq_o     (f_pri)
	);

	asb_interp #(
		.LW(12),
		.FW(16)
	) u_sec (
		.level_i    (secondary_level_i),
		.bias_lvl_i (st_reg.sbl),
		.gain_lvl_i (st_reg.sgl),
		.bias_f_i   (st_reg.sbf),
		.gain_f_i   (st_reg.sgf),
		.freq_o     (f_sec)
	);

	// full scale per active spec; bit0 of range picks 5 V
	always_comb begin
		fs_pri = primary_input_range_select_i[0] ? `ASB_FS_5V
			: `ASB_FS_10V;
		unique case (secondary_input_spec_select_i)
			`ASB_SPEC_20MA: fs_sec = `ASB_FS_20MA;
			`ASB_SPEC_5V:   fs_sec = `ASB_FS_5V;
			default:        fs_sec = `ASB_FS_10V;
		endcase
	end

	// one converter shared by all four level displays
	always_comb begin
		conv_lvl = st_reg.pbl;
		conv_fs = fs_pri;
		unique case (disp_sel_i)
			ASB_PGL: conv_lvl = st_reg.pgl;
			ASB_SBL: begin
				conv_lvl = st_reg.sbl;
				conv_fs = fs_sec;
			end
			ASB_SGL: begin
				conv_lvl = st_reg.sgl;
				conv_fs = fs_sec;
			end
			default: conv_lvl = st_reg.pbl;
		endcase
	end

	asb_unit_conv #(
		.LW(12)
	) u_conv (
		.level_i      (conv_lvl),
		.unit_i       (st_reg.unit),
		.full_scale_i (conv_fs),
		.disp_o       (conv_out)
	);

	// secondary only counts while its enable function is asserted
	assign f_sel = secondary_input_enable_i ? f_sec : f_pri;

	//--------------------------------------------------------------
	// write qualification
	//--------------------------------------------------------------

	always_comb begin
		// live mode takes the applied level, offline the typed one
		val = wr_data_i;
		if (cal_live_i && is_level(wr_sel_i)) begin
			val = (wr_sel_i == ASB_PBL || wr_sel_i == ASB_PGL)
				? 16'(primary_level_i)
				: 16'(secondary_level_i);
		end
		// unit select escapes the protect setting
		allow = (wr_sel_i == ASB_UNIT)
			|| (parameter_write_protect_i == `ASB_WP_ANY)
			|| (parameter_write_protect_i == `ASB_WP_STOP
			&& !running_i);
		is_freq = wr_sel_i == ASB_PGF || wr_sel_i == ASB_SGF
			|| wr_sel_i == ASB_PBF || wr_sel_i == ASB_SBF;
		if (is_level(wr_sel_i)) begin
			in_range = val <= `ASB_LVL_MAX;
		end else if (wr_sel_i == ASB_UNIT) begin
			in_range = val <= 16'h0001;
		end else begin
			in_range = (wr_sel_i <= ASB_ACC)
				&& val <= `ASB_FREQ_MAX;
		end
		// high gain needs the high speed limit raised first
		hs_block = (wr_sel_i == ASB_PGF || wr_sel_i == ASB_SGF)
			&& val >= `ASB_HS_LIMIT
			&& high_speed_max_frequency_i < `ASB_HS_LIMIT;
		unique case (wr_sel_i)
			ASB_PGF: partner = st_reg.pbf;
			ASB_PBF: partner = st_reg.pgf;
			ASB_SGF: partner = st_reg.sbf;
			default: partner = st_reg.sgf;
		endcase
		gap_bad = is_freq && !gap_ok(val, partner);
	end

	//--------------------------------------------------------------
	// next state
	//--------------------------------------------------------------

	always_comb begin
		st_next = st_reg;
		st_next.refused = 1'b0;
		if (wr_en_i) begin
			if (!allow || !in_range || hs_block) begin
				st_next.refused = 1'b1;
			end else if (gap_bad) begin
				st_next.err = 1'b1;
				st_next.refused = 1'b1;
			end else begin
				if (is_freq) begin
					st_next.err = 1'b0;
				end
				// each write touches only its own field
				unique case (wr_sel_i)
					ASB_PGF: st_next.pgf = val;
					ASB_SGF: st_next.sgf = val;
					ASB_UNIT: st_next.unit = val[0];
					ASB_PBF: st_next.pbf = val;
					ASB_PBL: st_next.pbl = val[11:0];
					ASB_PGL: st_next.pgl = val[11:0];
					ASB_SBF: st_next.sbf = val;
					ASB_SBL: st_next.sbl = val[11:0];
					ASB_SGL: st_next.sgl = val[11:0];
					default: st_next.accref = val;
				endcase
			end
		end
		st_next.setpt = f_sel;
		// start with no signal runs at the bias frequency
		st_next.cmd = start_i ? f_sel : 16'h0000;
		unique case (disp_sel_i)
			ASB_PGF: st_next.disp = st_reg.pgf;
			ASB_SGF: st_next.disp = st_reg.sgf;
			ASB_UNIT: st_next.disp = 16'(st_reg.unit);
			ASB_PBF: st_next.disp = st_reg.pbf;
			ASB_SBF: st_next.disp = st_reg.sbf;
			ASB_ACC: st_next.disp = st_reg.accref;
			default: st_next.disp = conv_out;
		endcase
		st_next.lamp = st_reg.unit && is_level(disp_sel_i);
	end

	// defaults land on the first edge of reset
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
			st_reg.pgf <= `ASB_RST_GAIN_F;
			st_reg.sgf <= `ASB_RST_GAIN_F;
			st_reg.pbf <= `ASB_RST_BIAS_F;
			st_reg.sbf <= `ASB_RST_BIAS_F;
			st_reg.pbl <= `ASB_RST_PBL;
			st_reg.pgl <= `ASB_RST_GL;
			st_reg.sbl <= `ASB_RST_SBL;
			st_reg.sgl <= `ASB_RST_GL;
			st_reg.accref <= `ASB_RST_ACCREF;
		end else begin
			st_reg <= st_next;
		end
	end

	//--------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------

	assign freq_setpoint_o = st_reg.setpt;
	assign freq_command_o = st_reg.cmd;
	assign accel_reference_frequency_o = st_reg.accref;
	assign display_value_o = st_reg.disp;
	assign level_display_unit_select_o = st_reg.unit;
	assign ampere_unit_lamp_o = st_reg.lamp;
	assign calibration_save_error_o = st_reg.err;
	assign wr_refused_o = st_reg.refused;

	//--------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_unit_wr;
		wr_en_i && wr_sel_i == ASB_UNIT && wr_data_i <= 16'h0001;
	endsequence

	sequence s_gain_wr;
		wr_en_i && (wr_sel_i == ASB_PGF || wr_sel_i == ASB_SGF);
	endsequence

	a_pri_low_clamp: assert property (
		!secondary_input_enable_i && primary_level_i <= st_reg.pbl
		|=> freq_setpoint_o == $past(st_reg.pbf))
		else $error("primary low clamp wrong");

	a_pri_high_clamp: assert property (
		!secondary_input_enable_i && primary_level_i > st_reg.pbl
		&& primary_level_i >= st_reg.pgl
		|=> freq_setpoint_o == $past(st_reg.pgf))
		else $error("primary high clamp wrong");

	a_sec_low_clamp: assert property (
		secondary_input_enable_i && secondary_level_i <= st_reg.sbl
		|=> freq_setpoint_o == $past(st_reg.sbf))
		else $error("secondary low clamp wrong");

	a_sec_high_clamp: assert property (
		secondary_input_enable_i && secondary_level_i > st_reg.sbl
		&& secondary_level_i >= st_reg.sgl
		|=> freq_setpoint_o == $past(st_reg.sgf))
		else $error("secondary high clamp wrong");

	a_unit_always_wr: assert property (
		s_unit_wr |=> level_display_unit_select_o == $past(wr_data_i[0])
		&& !wr_refused_o)
		else $error("unit select write lost");

	a_gain_keeps_lvl: assert property (
		s_gain_wr |=> $stable(st_reg.pgl) && $stable(st_reg.sgl)
		&& $stable(st_reg.pbl) && $stable(st_reg.sbl))
		else $error("gain write moved a level");

	a_lvl_keeps_acc: assert property (
		wr_en_i && is_level(wr_sel_i)
		|=> $stable(accel_reference_frequency_o))
		else $error("level write moved accel reference");

	a_range_reject: assert property (
		wr_en_i && is_level(wr_sel_i) && !cal_live_i
		&& wr_data_i > `ASB_LVL_MAX |=> wr_refused_o)
		else $error("out of range level taken");

	a_cmd_gated: assert property (
		##1 freq_command_o == ($past(start_i) ? freq_setpoint_o : 16'h0))
		else $error("command not gated by start");

	a_lamp_level: assert property (
		st_reg.unit && is_level(disp_sel_i) |=> ampere_unit_lamp_o)
		else $error("unit lamp dark");

	a_gap_error: assert property (
		wr_en_i && allow && in_range && !hs_block && gap_bad
		|=> calibration_save_error_o && wr_refused_o)
		else $error("close frequencies not flagged");

	a_live_capture: assert property (
		wr_en_i && cal_live_i && wr_sel_i == ASB_PBL && allow
		|=> st_reg.pbl == $past(primary_level_i)
		|| wr_refused_o)
		else $error("live capture missed");

endmodule

// *** testbench/asb_src_model.sv ***
`timescale 1ns/100ps
module asb_src_model (
	// clock
	input  wire logic        core_clk_i,
	// applied analog levels, 0.1 % steps
	output logic      [11:0] primary_level_o,
	output logic      [11:0] secondary_level_o
);
	// ------------------------------------------------------------
	// source behaviour
	// ------------------------------------------------------------
	// levels change at the falling edge so the scaler never samples
	// a level in the same time step in which it moves
	initial begin
		primary_level_o = 12'h000;
		secondary_level_o = 12'h000;
	end

	task automatic set_levels(input logic [11:0] p, input logic [11:0] s);
		@(negedge core_clk_i);
		primary_level_o = p;
		secondary_level_o = s;
	endtask
endmodule

// *** testbench/asb_scaler_tb.sv ***
`timescale 1ns/100ps
module asb_scaler_tb;
	import asb_pkg::*;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [11:0] p_lvl;
	logic [11:0] s_lvl;
	logic [3:0]  range_sel = 4'h1;
	logic [1:0]  spec_sel = 2'h0;
	logic        sec_en = 1'b0;
	logic        start = 1'b0;
	logic        running = 1'b0;
	logic [1:0]  protect = 2'h0;
	logic [15:0] hs_max = 16'h1388;
	logic        wr_en = 1'b0;
	logic [3:0]  wr_sel = 4'h0;
	logic [15:0] wr_data = 16'h0000;
	logic        cal_live = 1'b0;
	logic [3:0]  disp_sel = 4'h0;
	logic [15:0] setpt, cmd, accref, disp;
	logic        unit_o, lamp, err, refused;
	int          fails = 0;
	int          n_compared = 0;

	always #4 core_clk_i = ~core_clk_i;

	asb_src_model i_asb_src_model (
		.core_clk_i       (core_clk_i),
		.primary_level_o  (p_lvl),
		.secondary_level_o(s_lvl)
	);

	asb_scaler i_asb_scaler (
		.core_clk_i                   (core_clk_i),
		.rst_n_i                      (rst_n_i),
		.primary_level_i              (p_lvl),
		.secondary_level_i            (s_lvl),
		.primary_input_range_select_i (range_sel),
		.secondary_input_spec_select_i(spec_sel),
		.secondary_input_enable_i     (sec_en),
		.start_i                      (start),
		.running_i                    (running),
		.parameter_write_protect_i    (protect),
		.high_speed_max_frequency_i   (hs_max),
		.wr_en_i                      (wr_en),
		.wr_sel_i                     (wr_sel),
		.wr_data_i                    (wr_data),
		.cal_live_i                   (cal_live),
		.disp_sel_i                   (disp_sel),
		.freq_setpoint_o              (setpt),
		.freq_command_o               (cmd),
		.accel_reference_frequency_o  (accref),
		.display_value_o              (disp),
		.level_display_unit_select_o  (unit_o),
		.ampere_unit_lamp_o           (lamp),
		.calibration_save_error_o     (err),
		.wr_refused_o                 (refused)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// outputs lag inputs by up to two edges, so three falling edges
	task automatic settle;
		repeat (3) @(negedge core_clk_i);
	endtask

	// write strobe held for exactly one rising edge; the refusal pulse
	// is looked for over the next edges, bounded, and returned
	task automatic wr(input logic [3:0] s, input logic [15:0] d,
			input logic live, output logic ref_seen);
		@(negedge core_clk_i);
		wr_sel = s;
		wr_data = d;
		cal_live = live;
		wr_en = 1'b1;
		@(negedge core_clk_i);
		wr_en = 1'b0;
		cal_live = 1'b0;
		ref_seen = (refused === 1'b1);
		@(negedge core_clk_i);
		ref_seen = ref_seen | (refused === 1'b1);
	endtask

	task automatic show(input logic [3:0] s, input logic [15:0] exp);
		disp_sel = s;
		settle();
		check(disp, exp);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic sc_reset_values;
		show(ASB_PGF, 16'h1388);
		show(ASB_SGF, 16'h1388);
		show(ASB_PBF, 16'h0000);
		show(ASB_PBL, 16'h0000);
		show(ASB_SBL, 16'h00c8);
		show(ASB_SGL, 16'h03e8);
		check({15'h0000, unit_o}, 16'h0000);
		check(accref, 16'h1388);
	endtask

	task automatic sc_primary_curve;
		logic r;
		i_asb_src_model.set_levels(12'h1f4, 12'h000);
		settle();
		check(setpt, 16'h09c4);
		i_asb_src_model.set_levels(12'h5dc, 12'h000);
		settle();
		check(setpt, 16'h1388);
		// only the gain frequency moves, level points stay put
		wr(ASB_PGF, 16'h0fa0, 1'b0, r);
		i_asb_src_model.set_levels(12'h3e8, 12'h000);
		settle();
		check(setpt, 16'h0fa0);
		show(ASB_PGL, 16'h03e8);
		// bias above gain gives a falling slope
		wr(ASB_PBF, 16'h1770, 1'b0, r);
		i_asb_src_model.set_levels(12'h1f4, 12'h000);
		settle();
		check(setpt, 16'h1388);
		i_asb_src_model.set_levels(12'h000, 12'h000);
		settle();
		check(setpt, 16'h1770);
	endtask

	task automatic sc_secondary;
		sec_en = 1'b1;
		i_asb_src_model.set_levels(12'h000, 12'h064);
		settle();
		check(setpt, 16'h0000);
		i_asb_src_model.set_levels(12'h000, 12'h258);
		settle();
		check(setpt, 16'h09c4);
		i_asb_src_model.set_levels(12'h000, 12'h4b0);
		settle();
		check(setpt, 16'h1388);
		sec_en = 1'b0;
		settle();
		check(setpt, 16'h1770);
	endtask

	task automatic sc_refusals;
		logic r;
		wr(ASB_SBF, 16'h1324, 1'b0, r);
		check({15'h0000, r}, 16'h0001);
		check({15'h0000, err}, 16'h0001);
		show(ASB_SBF, 16'h0000);
		wr(ASB_SBF, 16'h03e8, 1'b0, r);
		check({15'h0000, err}, 16'h0000);
		wr(ASB_SGF, 16'h9c41, 1'b0, r);
		check({15'h0000, r}, 16'h0001);
		wr(ASB_PBL, 16'h0bb9, 1'b0, r);
		check({15'h0000, r}, 16'h0001);
		wr(ASB_PBL, 16'h0bb8, 1'b0, r);
		check({15'h0000, r}, 16'h0000);
		show(ASB_PBL, 16'h0bb8);
		wr(ASB_PBL, 16'h0000, 1'b0, r);
		// operator must raise the high speed limit first
		wr(ASB_SGF, 16'h2ee0, 1'b0, r);
		check({15'h0000, r}, 16'h0001);
		hs_max = 16'h2ee0;
		wr(ASB_SGF, 16'h2ee0, 1'b0, r);
		check({15'h0000, r}, 16'h0000);
		running = 1'b1;
		wr(ASB_PGF, 16'h1388, 1'b0, r);
		check({15'h0000, r}, 16'h0001);
		// protect code 2 lets a running write through, code 1 only a unit select write
		protect = 2'h2;
		wr(ASB_PGF, 16'h0fa0, 1'b0, r);
		check({15'h0000, r}, 16'h0000);
		protect = 2'h1;
		wr(ASB_PGF, 16'h0fa0, 1'b0, r);
		check({15'h0000, r}, 16'h0001);
		// unit select still goes in under the strictest protection
		wr(ASB_UNIT, 16'h0001, 1'b0, r);
		check({15'h0000, r}, 16'h0000);
		protect = 2'h0;
		running = 1'b0;
		// selection codes above the table are never stored
		wr(4'ha, 16'h0000, 1'b0, r);
		check({15'h0000, r}, 16'h0001);
	endtask

	task automatic sc_units;
		logic r;
		// unit select is already 1 from the protected-write scenario
		range_sel = 4'h1;
		show(ASB_PGL, 16'h01f4);
		check({15'h0000, lamp}, 16'h0001);
		show(ASB_PGF, 16'h0fa0);
		check({15'h0000, lamp}, 16'h0000);
		range_sel = 4'h0;
		show(ASB_PGL, 16'h03e8);
		spec_sel = 2'h0;
		show(ASB_SGL, 16'h07d0);
		spec_sel = 2'h1;
		show(ASB_SGL, 16'h01f4);
		spec_sel = 2'h2;
		show(ASB_SGL, 16'h03e8);
		wr(ASB_UNIT, 16'h0000, 1'b0, r);
		show(ASB_SGL, 16'h03e8);
		check({15'h0000, lamp}, 16'h0000);
		// spec changed, so the operator sets both secondary points again
		spec_sel = 2'h0;
		wr(ASB_SBL, 16'h00c8, 1'b0, r);
		check({15'h0000, r}, 16'h0000);
		wr(ASB_SGL, 16'h03e8, 1'b0, r);
		check({15'h0000, r}, 16'h0000);
		show(ASB_SBL, 16'h00c8);
	endtask

	task automatic sc_calibration;
		logic r;
		i_asb_src_model.set_levels(12'h0fa, 12'h0d2);
		wr(ASB_PBL, 16'h0000, 1'b1, r);
		show(ASB_PBL, 16'h00fa);
		// live capture takes the level of the point's own input
		wr(ASB_SBL, 16'h0000, 1'b1, r);
		show(ASB_SBL, 16'h00d2);
		wr(ASB_PBL, 16'h007b, 1'b0, r);
		show(ASB_PBL, 16'h007b);
		wr(ASB_PGL, 16'h0320, 1'b0, r);
		check(accref, 16'h1388);
		show(ASB_ACC, 16'h1388);
	endtask

	task automatic sc_start_only;
		i_asb_src_model.set_levels(12'h000, 12'h000);
		start = 1'b0;
		settle();
		check(cmd, 16'h0000);
		start = 1'b1;
		settle();
		check(cmd, 16'h1770);
		// reset in mid-run clears set point and command and restores every default
		rst_n_i = 1'b0;
		settle();
		check(setpt, 16'h0000);
		check(cmd, 16'h0000);
		rst_n_i = 1'b1;
		show(ASB_PBL, 16'h0000);
		show(ASB_PGF, 16'h1388);
		check(cmd, 16'h0000);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		sc_reset_values();
		sc_primary_curve();
		sc_secondary();
		sc_refusals();
		sc_units();
		sc_calibration();
		sc_start_only();
		finish_test();
	end
endmodule
